/* File: brpa_consts.vh */
// constants and behaviour notes for the burst rom / card bus arbiter
// Notes on behaviour
// - non-zero burst length turns areas 0, 5, 6 into burst rom
// - chip select stays asserted between burst beats; only address advances
// - beats: 8-bit rom 4/8/16, 16-bit rom 4/8, 32-bit rom 4
// - wait pin sampled on first beat only if waits set; always later
// - zero-wait burst rom: later beats still take two cycles
// - card select bit makes area 5 memory card, area 6 memory plus io
// - card areas use 8 or 16 bit width from their size bits
// - lower 32 mbyte of a card area runs memory-card cycles
// - card areas get setup/hold extensions plus software and pin waits
// - memory-card page burst applies to reads only, never writes
// - io-card cycles only area 6, addresses 1a000000 to 1bffffff
// - little endian 16-bit area 6: io width sense high splits word
// - big endian ignores io width sense; system holds it low
// - idle inserted on area change or write after read only
// - idle count per area from two-bit field, minus empty cycles
// - no idle insertion after a bus arbitration handover
// - release request: finish cycle, grant, never during cache fill
// - while released, assert bus retrieve when device needs bus
// - retrieve on pending refresh or interrupt above mask level
// - area 6 16-bit: byte after word/long asserts both card enables
// - refresh during area 6 card access keeps area 6 select asserted
`ifndef BRPA_CONSTS_VH
`define BRPA_CONSTS_VH
`define BRPA_IO_BASE 32'h1A00_0000
`define BRPA_IO_LAST 32'h1BFF_FFFF
`define BRPA_CARD_SPAN_BIT 25
`define BRPA_AREA_BIT 26
`define BRPA_SZ_8 2'h0
`define BRPA_SZ_16 2'h2
`define BRPA_SZ_32 2'h3
`define BRPA_BEAT_CNT_W 5
`endif

/* File: brpa_counter.v */
// loadable down counter used for wait, idle and setup/hold phases
`timescale 1ns/100ps
module brpa_counter (
	input wire clk_in,
	input wire resetn_in,
	input wire load_in,
	input wire [4:0] value_in,
	output wire zero_out
);
	reg [4:0] count_reg;

	// load wins over count-down
	always @(posedge clk_in) begin
		if (!resetn_in) begin
			count_reg <= 5'h0_0;
		end else if (load_in) begin
			count_reg <= value_in;
		end else if (count_reg != 5'h0_0) begin
			count_reg <= count_reg - 5'h0_1;
		end
	end

	assign zero_out = (count_reg == 5'h0_0);
endmodule // brpa_counter

/* File: brpa_partner.sv */
// far side model: rom wait source, io card sizing, external bus master
`timescale 1ns/100ps
module brpa_partner (
	input wire clk_in,
	input wire want_bus_in,
	input wire [2:0] hold_wait_in,
	input wire narrow_io_in,
	input wire little_endian_in,
	input wire rd_n_in,
	input wire wr_n_in,
	input wire bus_retrieve_n_in,
	output reg wait_n_out,
	output reg io_width_sense_out,
	output reg bus_release_request_n_out
);
	reg [2:0] cnt_reg;
	initial begin
		{cnt_reg, io_width_sense_out} = 4'h0;
		{wait_n_out, bus_release_request_n_out} = 2'h3;
	end
	// wait low for the first cycles of a strobe, pull-up level otherwise
	always @(posedge clk_in) begin
		cnt_reg <= (rd_n_in && wr_n_in) ? 3'h0 : cnt_reg + (cnt_reg != 3'h7);
		wait_n_out <= (rd_n_in && wr_n_in) || cnt_reg >= hold_wait_in;
		io_width_sense_out <= little_endian_in && narrow_io_in;
		bus_release_request_n_out <= !(want_bus_in && bus_retrieve_n_in);
	end
endmodule // brpa_partner

/* File: brpa_props.sv */
// port assertions for the external bus sequencer
`timescale 1ns/100ps
module brpa_props (
	input wire clk_in,
	input wire resetn_in,
	input wire req_cache_fill_in,
	input wire refresh_pending_in,
	input wire refresh_active_in,
	input wire irq_above_mask_in,
	input wire bus_release_request_n_in,
	input wire req_ready_out,
	input wire area0_chip_select_n_out,
	input wire area5_chip_select_n_out,
	input wire area6_chip_select_n_out,
	input wire rd_n_out,
	input wire wr_n_out,
	input wire io_cycle_out,
	input wire bus_drive_en_out,
	input wire bus_grant_n_out,
	input wire bus_retrieve_out_n_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	// any area selected, any strobe low
	wire sel = !(area0_chip_select_n_out && area5_chip_select_n_out &&
		area6_chip_select_n_out);
	wire stb = !(rd_n_out && wr_n_out);
	wire cause = irq_above_mask_in || refresh_pending_in && !refresh_active_in;
	a_strobe_has_select: assert property (
		stb |-> sel) else $error("strobe without chip select");
	a_io_only_area6: assert property (
		io_cycle_out && stb |-> area0_chip_select_n_out &&
		area5_chip_select_n_out) else $error("io cycle outside area 6");
	a_grant_no_select: assert property (
		!bus_grant_n_out |-> !sel && !stb) else $error("busy while granted");
	a_grant_no_drive: assert property (
		!bus_grant_n_out |-> !bus_drive_en_out) else $error("driving when granted");
	a_grant_when_idle: assert property (
		$fell(bus_grant_n_out) |-> $past(!sel && !stb))
		else $error("bus released mid cycle");
	a_no_grant_unasked: assert property (
		bus_release_request_n_in [*6] |-> bus_grant_n_out)
		else $error("grant without request");
	a_fill_not_released: assert property (
		sel && req_cache_fill_in |=> bus_grant_n_out)
		else $error("released during cache fill");
	a_retrieve_released: assert property (
		!bus_retrieve_out_n_out |-> !bus_grant_n_out)
		else $error("retrieve while owning bus");
	a_retrieve_on_cause: assert property (
		!bus_grant_n_out && $past(!bus_grant_n_out) && $past(cause)
		|-> !bus_retrieve_out_n_out) else $error("retrieve missing");
	c_granted: cover property (!bus_grant_n_out);
	c_retrieve: cover property (!bus_retrieve_out_n_out);
	c_io_read: cover property (io_cycle_out && !rd_n_out);
endmodule // brpa_props
bind brpa_top brpa_props u_props (.clk_in, .resetn_in, .req_cache_fill_in,
	.refresh_pending_in, .refresh_active_in, .irq_above_mask_in,
	.bus_release_request_n_in, .req_ready_out, .area0_chip_select_n_out,
	.area5_chip_select_n_out, .area6_chip_select_n_out, .rd_n_out,
	.wr_n_out, .io_cycle_out, .bus_drive_en_out, .bus_grant_n_out,
	.bus_retrieve_out_n_out);

/* File: brpa_sync.v */
// three-stage synchroniser; output changes when stages two and three agree
`timescale 1ns/100ps
module brpa_sync (
	input wire clk_in,
	input wire resetn_in,
	input wire pin_in,
	output wire level_out
);
	reg s1_reg;
	reg s2_reg;
	reg s3_reg;
	reg level_reg;

	// first stage feeds only the second
	always @(posedge clk_in) begin
		if (!resetn_in) begin
			s1_reg <= 1'b1;
			s2_reg <= 1'b1;
			s3_reg <= 1'b1;
			level_reg <= 1'b1;
		end else begin
			s1_reg <= pin_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg) begin
				level_reg <= s3_reg;
			end
		end
	end

	assign level_out = level_reg;
endmodule // brpa_sync

/* File: brpa_top.v */
// external bus sequencer: burst rom, card cycles, idle insertion, arbitration
`timescale 1ns/100ps
`include "brpa_consts.vh"
module brpa_top (
	input wire clk_in,
	input wire resetn_in,
	input wire req_valid_in,
	input wire [31:0] req_addr_in,
	input wire req_write_in,
	input wire [1:0] req_size_in,
	input wire req_cache_fill_in,
	output reg req_ready_out,
	input wire [1:0] area0_burst_length_in,
	input wire [1:0] area5_burst_length_in,
	input wire [1:0] area6_burst_length_in,
	input wire [1:0] area0_width_in,
	input wire [1:0] area5_width_in,
	input wire [1:0] area6_width_in,
	input wire area5_card_select_in,
	input wire area6_card_select_in,
	input wire [2:0] area0_waits_in,
	input wire [2:0] area5_waits_in,
	input wire [2:0] area6_waits_in,
	input wire [1:0] card_setup_in,
	input wire [1:0] card_hold_in,
	input wire [13:0] area_idle_count_in,
	input wire little_endian_in,
	input wire wait_n_in,
	input wire io_width_sense_in,
	input wire bus_release_request_n_in,
	input wire refresh_pending_in,
	input wire refresh_active_in,
	input wire irq_above_mask_in,
	output reg [31:0] addr_out,
	output reg area0_chip_select_n_out,
	output reg area5_chip_select_n_out,
	output reg area6_chip_select_n_out,
	output reg card_a_enable_high_n_out,
	output reg card_b_enable_high_n_out,
	output reg rd_n_out,
	output reg wr_n_out,
	output reg io_cycle_out,
	output reg byte_lane_odd_out,
	output reg bus_drive_en_out,
	output reg bus_grant_n_out,
	output reg bus_retrieve_out_n_out
);
	localparam [6:0] ST_IDLE = 7'b000_0001;
	localparam [6:0] ST_GAP = 7'b000_0010;
	localparam [6:0] ST_SETUP = 7'b000_0100;
	localparam [6:0] ST_STROBE = 7'b000_1000;
	localparam [6:0] ST_HOLD = 7'b001_0000;
	localparam [6:0] ST_BEAT = 7'b010_0000;
	localparam [6:0] ST_REL = 7'b100_0000;

	wire wait_n_s;
	wire io16_s;
	wire bus_release_request_n_s;
	wire cnt_zero;
	reg cnt_load;
	reg [4:0] cnt_value;
	reg [6:0] state_reg;
	reg [6:0] state_next;
	reg [2:0] area_reg;
	reg write_reg;
	reg [2:0] prev_area_reg;
	reg prev_write_reg;
	reg prev_valid_reg;
	reg [4:0] empty_reg;
	reg [4:0] beats_reg;
	reg [1:0] size_reg;
	reg card_reg;
	reg split_reg;
	reg half_reg;
	reg wide_prev_reg;
	reg cs6_hold_reg;
	reg first_reg;

	brpa_sync u_sync_wait (.clk_in(clk_in), .resetn_in(resetn_in),
		.pin_in(wait_n_in), .level_out(wait_n_s));
	brpa_sync u_sync_io16 (.clk_in(clk_in), .resetn_in(resetn_in),
		.pin_in(io_width_sense_in), .level_out(io16_s));
	brpa_sync u_sync_bus_release_request (.clk_in(clk_in), .resetn_in(resetn_in),
		.pin_in(bus_release_request_n_in), .level_out(bus_release_request_n_s));
	brpa_counter u_cnt (.clk_in(clk_in), .resetn_in(resetn_in),
		.load_in(cnt_load), .value_in(cnt_value), .zero_out(cnt_zero));

	// decode of the incoming request
	wire [2:0] req_area = req_addr_in[28:26];
	wire req_card = (req_area == 3'd5 && area5_card_select_in) ||
		(req_area == 3'd6 && area6_card_select_in);
	wire req_io = req_card && req_area == 3'd6 &&
		req_addr_in[28:0] >= `BRPA_IO_BASE &&
		req_addr_in[28:0] <= `BRPA_IO_LAST;
	wire req_mem_card = req_card && !req_io &&
		!req_addr_in[`BRPA_CARD_SPAN_BIT];
	wire [1:0] req_blen = (req_area == 3'd0) ? area0_burst_length_in :
		(req_area == 3'd5) ? area5_burst_length_in :
		(req_area == 3'd6) ? area6_burst_length_in : 2'h0;
	wire [1:0] req_width = (req_area == 3'd5) ? area5_width_in :
		(req_area == 3'd6) ? area6_width_in : area0_width_in;
	wire [2:0] req_waits = (req_area == 3'd5) ? area5_waits_in :
		(req_area == 3'd6) ? area6_waits_in : area0_waits_in;
	wire req_rom_burst = !req_card && req_blen != 2'h0;
	wire req_card_burst = req_mem_card && !req_write_in &&
		req_blen != 2'h0;

	// beat count from burst length and rom width
	reg [4:0] beat_total;
	always @* begin
		beat_total = 5'h0_1;
		if (req_rom_burst || req_card_burst) begin
			case (req_width)
				`BRPA_SZ_8: beat_total = (req_blen == 2'h1) ? 5'h0_4 :
					(req_blen == 2'h2) ? 5'h0_8 : 5'h1_0;
				`BRPA_SZ_16: beat_total = (req_blen == 2'h1) ? 5'h0_4 :
					5'h0_8;
				default: beat_total = 5'h0_4;
			endcase
		end
	end

	// idle cycles owed after the previous access, minus empty cycles
	wire [1:0] idle_field = area_idle_count_in[prev_area_reg*2 +: 2];
	wire need_gap = prev_valid_reg && (prev_area_reg != req_area ||
		(req_write_in && !prev_write_reg));
	wire [4:0] idle_owed = ({3'h0, idle_field} > empty_reg) ?
		({3'h0, idle_field} - empty_reg) : 5'h0_0;
	// the done cycle still shows the finished request; never take it twice
	wire start_ok = req_valid_in && bus_release_request_n_s && !req_ready_out;
	wire split_now = card_reg && area_reg == 3'd6 && io_cycle_out &&
		little_endian_in && io16_s && size_reg == 2'h1 &&
		area6_width_in == `BRPA_SZ_16;
	wire [2:0] cur_waits = (area_reg == 3'd5) ? area5_waits_in :
		(area_reg == 3'd6) ? area6_waits_in : area0_waits_in;
	wire sample_wait = !first_reg || cur_waits != 3'h0;

	// next state
	always @* begin
		state_next = state_reg;
		cnt_load = 1'b0;
		cnt_value = 5'h0_0;
		case (state_reg)
			ST_IDLE: begin
				if (!bus_release_request_n_s) begin
					state_next = ST_REL;
				end else if (start_ok && need_gap && idle_owed != 5'h0_0) begin
					state_next = ST_GAP;
					cnt_load = 1'b1;
					cnt_value = idle_owed - 5'h0_1;
				end else if (start_ok) begin
					state_next = req_card ? ST_SETUP : ST_STROBE;
					cnt_load = 1'b1;
					cnt_value = req_card ? {3'h0, card_setup_in} :
						{2'h0, req_waits};
				end
			end
			ST_GAP: begin
				if (cnt_zero) begin
					state_next = ST_IDLE;
				end
			end
			ST_SETUP: begin
				if (cnt_zero) begin
					state_next = ST_STROBE;
					cnt_load = 1'b1;
					cnt_value = {2'h0, cur_waits};
				end
			end
			ST_STROBE: begin
				if (cnt_zero && (!sample_wait || wait_n_s)) begin
					if (beats_reg > 5'h0_1) begin
						state_next = ST_BEAT;
						cnt_load = 1'b1;
						cnt_value = (cur_waits == 3'h0) ? 5'h0_1 :
							{2'h0, cur_waits};
					end else if (card_reg) begin
						state_next = ST_HOLD;
						cnt_load = 1'b1;
						cnt_value = {3'h0, card_hold_in};
					end else begin
						state_next = ST_IDLE;
					end
				end
			end
			ST_BEAT: begin
				state_next = ST_STROBE;
			end
			ST_HOLD: begin
				if (cnt_zero) begin
					state_next = (split_now && !half_reg) ? ST_SETUP : ST_IDLE;
					cnt_load = split_now && !half_reg;
					cnt_value = {3'h0, card_setup_in};
				end
			end
			ST_REL: begin
				if (bus_release_request_n_s) begin
					state_next = ST_IDLE;
				end
			end
			default: state_next = ST_IDLE;
		endcase
	end

	// sequencing registers and pin drivers
	always @(posedge clk_in) begin
		if (!resetn_in) begin
			state_reg <= ST_IDLE;
			area_reg <= 3'h0;
			write_reg <= 1'b0;
			prev_area_reg <= 3'h0;
			prev_write_reg <= 1'b0;
			prev_valid_reg <= 1'b0;
			empty_reg <= 5'h0_0;
			beats_reg <= 5'h0_0;
			size_reg <= 2'h0;
			card_reg <= 1'b0;
			split_reg <= 1'b0;
			half_reg <= 1'b0;
			wide_prev_reg <= 1'b0;
			cs6_hold_reg <= 1'b0;
			first_reg <= 1'b0;
			req_ready_out <= 1'b0;
			addr_out <= 32'h0000_0000;
			area0_chip_select_n_out <= 1'b1;
			area5_chip_select_n_out <= 1'b1;
			area6_chip_select_n_out <= 1'b1;
			card_a_enable_high_n_out <= 1'b1;
			card_b_enable_high_n_out <= 1'b1;
			rd_n_out <= 1'b1;
			wr_n_out <= 1'b1;
			io_cycle_out <= 1'b0;
			byte_lane_odd_out <= 1'b0;
			bus_drive_en_out <= 1'b1;
			bus_grant_n_out <= 1'b1;
			bus_retrieve_out_n_out <= 1'b1;
		end else begin
			state_reg <= state_next;
			req_ready_out <= 1'b0;
			if (state_reg == ST_IDLE && state_next != ST_GAP &&
				state_next != ST_REL && start_ok) begin
				// latch the request and drive the selects
				area_reg <= req_area;
				write_reg <= req_write_in;
				size_reg <= req_size_in;
				card_reg <= req_card;
				io_cycle_out <= req_io;
				beats_reg <= req_cache_fill_in ? 5'h0_1 : beat_total;
				first_reg <= 1'b1;
				half_reg <= 1'b0;
				addr_out <= req_addr_in;
				byte_lane_odd_out <= req_addr_in[0];
				area0_chip_select_n_out <= !(req_area == 3'd0);
				area5_chip_select_n_out <= !(req_area == 3'd5);
				area6_chip_select_n_out <= !(req_area == 3'd6);
				card_a_enable_high_n_out <= !(req_card && req_area == 3'd5 &&
					req_width == `BRPA_SZ_16 && req_size_in != 2'h0);
				card_b_enable_high_n_out <= !(req_card && req_area == 3'd6 &&
					req_width == `BRPA_SZ_16 &&
					(req_size_in != 2'h0 || wide_prev_reg));
				wide_prev_reg <= req_card && req_area == 3'd6 &&
					req_size_in != 2'h0;
				empty_reg <= 5'h0_0;
			end else if ((state_reg == ST_IDLE || state_reg == ST_GAP) &&
				empty_reg != 5'h1_F) begin
				// gap cycles are empty too, so a paid gap is not owed again
				empty_reg <= empty_reg + 5'h0_1;
			end
			if (state_next == ST_STROBE) begin
				rd_n_out <= write_reg ? 1'b1 : 1'b0;
				wr_n_out <= write_reg ? 1'b0 : 1'b1;
				if (state_reg == ST_IDLE) begin
					rd_n_out <= req_write_in;
					wr_n_out <= !req_write_in;
				end
			end else begin
				rd_n_out <= 1'b1;
				wr_n_out <= 1'b1;
			end
			if (state_reg == ST_STROBE && state_next == ST_BEAT) begin
				// chip select held, only the address moves
				beats_reg <= beats_reg - 5'h0_1;
				first_reg <= 1'b0;
				addr_out <= addr_out + {27'h0, (5'h0_1 << size_reg)};
			end
			if (state_reg == ST_HOLD && state_next == ST_SETUP) begin
				// second half of a split io word on the odd byte lane
				half_reg <= 1'b1;
				byte_lane_odd_out <= 1'b1;
				addr_out <= addr_out + 32'h0000_0001;
			end
			if (state_reg != ST_IDLE && state_next == ST_IDLE &&
				state_reg != ST_GAP && state_reg != ST_REL) begin
				prev_area_reg <= area_reg;
				prev_write_reg <= write_reg;
				prev_valid_reg <= 1'b1;
				req_ready_out <= 1'b1;
				area0_chip_select_n_out <= 1'b1;
				area5_chip_select_n_out <= 1'b1;
				card_a_enable_high_n_out <= 1'b1;
				card_b_enable_high_n_out <= 1'b1;
				if (cs6_hold_reg && area_reg == 3'd6) begin
					cs6_hold_reg <= 1'b0;
				end
				area6_chip_select_n_out <= !(cs6_hold_reg && area_reg != 3'd6);
			end
			// refresh overlapping an area 6 card cycle keeps that select
			if (refresh_active_in && card_reg && area_reg == 3'd6 &&
				state_reg != ST_IDLE) begin
				cs6_hold_reg <= 1'b1;
			end
			if (cs6_hold_reg) begin
				area6_chip_select_n_out <= 1'b0;
			end
			if (state_next == ST_REL) begin
				bus_grant_n_out <= 1'b0;
				bus_drive_en_out <= 1'b0;
				prev_valid_reg <= 1'b0;
			end else if (state_reg == ST_REL) begin
				bus_grant_n_out <= 1'b1;
				bus_drive_en_out <= 1'b1;
			end
			bus_retrieve_out_n_out <= !(state_next == ST_REL &&
				((refresh_pending_in && !refresh_active_in) ||
				irq_above_mask_in));
			if (state_reg == ST_STROBE && split_now) begin
				split_reg <= 1'b1;
			end else if (state_next == ST_IDLE) begin
				split_reg <= 1'b0;
			end
		end
	end
endmodule // brpa_top

/* File: brpa_top_test.sv */
// self-checking bench for the external bus sequencer
`timescale 1ns/100ps
module brpa_top_test;
	reg clk_in, resetn_in, req_valid_in, req_write_in, req_cache_fill_in;
	reg [31:0] req_addr_in;
	reg [1:0] req_size_in, area0_burst_length_in, area5_burst_length_in;
	reg [1:0] area6_burst_length_in, area0_width_in, area5_width_in;
	reg [1:0] area6_width_in, card_setup_in, card_hold_in;
	reg area5_card_select_in, area6_card_select_in, little_endian_in;
	reg refresh_pending_in, refresh_active_in, irq_above_mask_in, want, narrow;
	reg [2:0] area0_waits_in, area5_waits_in, area6_waits_in, hw;
	reg [13:0] area_idle_count_in;
	wire wait_n_in, io_width_sense_in, bus_release_request_n_in;
	wire req_ready_out, area0_chip_select_n_out, area5_chip_select_n_out;
	wire area6_chip_select_n_out, card_a_enable_high_n_out, rd_n_out;
	wire card_b_enable_high_n_out, wr_n_out, io_cycle_out, byte_lane_odd_out;
	wire bus_drive_en_out, bus_grant_n_out, bus_retrieve_out_n_out;
	wire [31:0] addr_out;
	integer n_fail, cmp_count, t, ta, nstb, ncs, i, j, k, s, h;
	reg [2:0] cs_seen, cs_q;
	reg io_seen, odd_seen, ceb_seen, cea_seen, stb_q;
	wire [2:0] cs = ~{area6_chip_select_n_out, area5_chip_select_n_out,
		area0_chip_select_n_out};
	wire stb = !(rd_n_out && wr_n_out);
	brpa_top u_dut (.clk_in, .resetn_in, .req_valid_in, .req_addr_in,
		.req_write_in, .req_size_in, .req_cache_fill_in, .req_ready_out,
		.area0_burst_length_in, .area5_burst_length_in, .area6_burst_length_in,
		.area0_width_in, .area5_width_in, .area6_width_in, .area5_card_select_in,
		.area6_card_select_in, .area0_waits_in, .area5_waits_in, .area6_waits_in,
		.card_setup_in, .card_hold_in, .area_idle_count_in, .little_endian_in,
		.wait_n_in, .io_width_sense_in, .bus_release_request_n_in,
		.refresh_pending_in, .refresh_active_in, .irq_above_mask_in, .addr_out,
		.area0_chip_select_n_out, .area5_chip_select_n_out,
		.area6_chip_select_n_out, .card_a_enable_high_n_out,
		.card_b_enable_high_n_out, .rd_n_out, .wr_n_out, .io_cycle_out,
		.byte_lane_odd_out, .bus_drive_en_out, .bus_grant_n_out,
		.bus_retrieve_out_n_out);
	brpa_partner u_far (.clk_in(clk_in), .want_bus_in(want), .hold_wait_in(hw),
		.narrow_io_in(narrow), .little_endian_in(little_endian_in),
		.rd_n_in(rd_n_out), .wr_n_in(wr_n_out),
		.bus_retrieve_n_in(bus_retrieve_out_n_out), .wait_n_out(wait_n_in),
		.io_width_sense_out(io_width_sense_in),
		.bus_release_request_n_out(bus_release_request_n_in));
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	// strobe and select monitor for the access in flight
	always @(posedge clk_in) begin
		nstb = nstb + (stb && !stb_q);
		ncs = ncs + (cs != 3'h0 && cs_q == 3'h0);
		cs_seen = cs_seen | cs;
		io_seen = io_seen | (stb && io_cycle_out);
		odd_seen = odd_seen | (stb && byte_lane_odd_out);
		ceb_seen = ceb_seen | (stb && !card_b_enable_high_n_out);
		cea_seen = cea_seen | (stb && !card_a_enable_high_n_out);
		stb_q = stb;
		cs_q = cs;
	end
	// expected beats of a burst rom read
	function integer beats(input [1:0] wd, input [1:0] code);
		if (code == 2'h0)
			beats = 1;
		else if (wd == 2'h0)
			beats = 4 << (code - 1);
		else
			beats = (wd == 2'h2 && code != 2'h1) ? 8 : 4;
	endfunction
	task chk(input [95:0] nm, input [31:0] e, input [31:0] g);
		begin
			cmp_count = cmp_count + 1;
			if (g !== e) begin
				n_fail = n_fail + 1;
				$display("ERROR %0s expected %0h seen %0h", nm, e, g);
			end
		end
	endtask
	// one access: hold request until ready is sampled high
	task acc(input [31:0] a, input w, input [1:0] sz);
		begin
			@(posedge clk_in);
			req_addr_in <= a;
			req_write_in <= w;
			req_size_in <= sz;
			req_valid_in <= 1'b1;
			{nstb, ncs, t} = 0;
			{cs_seen, io_seen, odd_seen, ceb_seen, cea_seen} = 7'h00;
			while (req_ready_out !== 1'b1 && t < 400) begin
				@(posedge clk_in);
				t = t + 1;
			end
			req_valid_in <= 1'b0;
			chk("ready", 1, req_ready_out);
		end
	endtask
	// wait bounded for grant (sel 0) or retrieve (sel 1) to reach v
	task hold_for(input integer sel, input v);
		begin
			i = 0;
			while ((sel == 0 ? bus_grant_n_out : bus_retrieve_out_n_out) !== v
				&& i < 60) begin
				@(posedge clk_in);
				i = i + 1;
			end
			chk(sel == 0 ? "grant" : "retrieve", v,
				sel == 0 ? bus_grant_n_out : bus_retrieve_out_n_out);
		end
	endtask
	task test_done;
		begin
			$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
			if (n_fail == 0 && cmp_count > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask
	initial begin
		#600000;
		n_fail = n_fail + 1;
		test_done;
	end
	initial begin
		{req_valid_in, req_write_in, req_cache_fill_in, req_addr_in} = 0;
		{req_size_in, area0_burst_length_in, area5_burst_length_in} = 0;
		{area6_burst_length_in, area0_width_in, area5_width_in} = 0;
		{area6_width_in, card_setup_in, card_hold_in, area_idle_count_in} = 0;
		{area5_card_select_in, area6_card_select_in, little_endian_in} = 0;
		{refresh_pending_in, refresh_active_in, irq_above_mask_in} = 0;
		{want, narrow, area0_waits_in, area5_waits_in, area6_waits_in, hw} = 0;
		{n_fail, cmp_count, nstb, ncs, cs_seen, cs_q, stb_q} = 0;
		resetn_in = 1'b0;
		void'($urandom(32'hc1c0));
		repeat (3) @(posedge clk_in);
		resetn_in <= 1'b1;
		repeat (5) @(posedge clk_in);
		// every width and length code on areas 0, 5 and 6
		for (j = 0; j < 36; j = j + 1) begin
			k = (j / 4) % 3;
			s = (k == 0) ? 0 : k + 1;
			{area0_width_in, area5_width_in, area6_width_in} <= {3{s[1:0]}};
			{area0_burst_length_in, area5_burst_length_in} <= {2{j[1:0]}};
			area6_burst_length_in <= j[1:0];
			area0_waits_in <= $urandom % 8;
			area5_waits_in <= $urandom % 8;
			area6_waits_in <= $urandom % 8;
			h = (j < 12) ? 0 : (j < 24) ? 5 : 6;
			acc({3'h0, h[2:0], 26'h0}, 1'b0, 2'h0);
			chk("beats", beats(s[1:0], j[1:0]), nstb);
			chk("cs falls", 1, ncs);
			chk("cs area", (h == 0) ? 1 : (h == 5) ? 2 : 4, cs_seen);
			chk("end addr", {3'h0, h[2:0], 26'h0} +
				beats(s[1:0], j[1:0]) - 1, addr_out);
		end
		{area0_width_in, area0_waits_in, area0_burst_length_in} <= 0;
		acc(32'h0000_0000, 1'b0, 2'h0);
		ta = t;
		area0_burst_length_in <= 2'h1;
		acc(32'h0000_0000, 1'b0, 2'h0);
		chk("beat time", ta + 6, t);
		area0_burst_length_in <= 2'h0;
		k = $urandom % 8;
		area0_waits_in <= k;
		acc(32'h0000_0000, 1'b0, 2'h0);
		chk("sw waits", ta + k, t);
		area0_waits_in <= 3'h5;
		acc(32'h0000_0000, 1'b0, 2'h0);
		ta = t;
		hw <= 3'h6;
		acc(32'h0000_0000, 1'b0, 2'h0);
		chk("hw wait", 1, t > ta);
		hw <= 3'h0;
		// card area 5: setup, hold and waits add up
		{area5_card_select_in, area5_width_in, area5_burst_length_in} <= 5'h18;
		{area5_waits_in, card_setup_in, card_hold_in} <= 0;
		acc(32'h1400_0000, 1'b0, 2'h1);
		ta = t;
		chk("io a5", 0, io_seen);
		chk("cs a5", 2, cs_seen);
		chk("ce a5", 1, cea_seen);
		k = $urandom % 8;
		s = $urandom % 4;
		h = $urandom % 4;
		area5_waits_in <= k;
		card_setup_in <= s;
		card_hold_in <= h;
		acc(32'h1400_0000, 1'b0, 2'h1);
		chk("card time", ta + k + s + h, t);
		// card area 6: page burst, io window, sizing, byte after word
		{area6_card_select_in, area6_width_in, little_endian_in} <= 4'hD;
		{area6_burst_length_in, area6_waits_in} <= 5'h08;
		acc(32'h1800_0000, 1'b0, 2'h1);
		chk("rd burst", 4, nstb);
		chk("io mem", 0, io_seen);
		chk("cs a6", 4, cs_seen);
		acc(32'h1800_0000, 1'b1, 2'h1);
		chk("wr burst", 1, nstb);
		acc(32'h1800_0001, 1'b1, 2'h0);
		chk("both ce", 1, ceb_seen);
		area6_burst_length_in <= 2'h0;
		narrow <= 1'b1;
		acc(32'h1A00_0010, 1'b0, 2'h1);
		chk("io cycle", 1, io_seen);
		chk("split", 2, nstb);
		chk("odd lane", 1, odd_seen);
		little_endian_in <= 1'b0;
		acc(32'h1A00_0010, 1'b0, 2'h1);
		chk("no split", 1, nstb);
		{narrow, area5_card_select_in, area6_card_select_in} <= 3'h0;
		// idle insertion on area change and write after read
		area_idle_count_in <= 14'h3fff;
		acc(32'h0000_0000, 1'b1, 2'h2);
		acc(32'h0000_0000, 1'b1, 2'h2);
		ta = t;
		acc(32'h0000_0000, 1'b0, 2'h2);
		acc(32'h0000_0000, 1'b1, 2'h2);
		chk("rd to wr", 1, t > ta);
		acc(32'h1400_0000, 1'b0, 2'h2);
		ta = t;
		acc(32'h1400_0000, 1'b0, 2'h2);
		chk("new area", 1, ta > t);
		ta = t;
		area_idle_count_in <= 14'h0000;
		acc(32'h0000_0000, 1'b0, 2'h2);
		acc(32'h1400_0000, 1'b0, 2'h2);
		chk("zero idle", ta, t);
		// release request during a cache fill, then retrieve causes
		req_cache_fill_in <= 1'b1;
		want <= 1'b1;
		acc(32'h0000_0000, 1'b0, 2'h2);
		req_cache_fill_in <= 1'b0;
		for (j = 0; j < 2; j = j + 1) begin
			want <= 1'b1;
			hold_for(0, 1'b0);
			req_valid_in <= 1'b1;
			repeat (10) @(posedge clk_in);
			chk("refused", 0, req_ready_out);
			req_valid_in <= 1'b0;
			if (j == 0)
				irq_above_mask_in <= 1'b1;
			else
				refresh_pending_in <= 1'b1;
			hold_for(1, 1'b0);
			want <= 1'b0;
			hold_for(0, 1'b1);
			{irq_above_mask_in, refresh_pending_in} <= 2'h0;
			acc(32'h0000_0000, 1'b0, 2'h2);
		end
		test_done;
	end
endmodule // brpa_top_test
